//--- rtl/fsp_pkg.sv
// Constants, command codes and types of the flash sector protection block.
// Assumes one 20 MHz clock domain shared by every file that imports it.
package fsp_pkg;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_MODE_ENTRY = 16'h0040;
  localparam logic [15:0] CMD_GUARD_ENTRY = 16'h00c0;
  localparam logic [15:0] CMD_FREEZE_ENTRY = 16'h0050;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
  localparam logic [15:0] CMD_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_ERASE = 16'h0080;
  localparam logic [15:0] CMD_ERASE_GO = 16'h0030;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h2aa;
  localparam int UL_HI = 11;
  localparam int SEC_HI = 23;
  localparam int SEC_LO = 14;
  localparam int BANK_HI = 23;
  localparam int BANK_LO = 20;
  localparam logic [3:0] BANK0 = 4'h0;
  localparam int MR_SECURE = 0;
  localparam int MR_PERSIST = 1;
  localparam int MR_PASSWORD = 2;
  localparam int MR_ERASE_EN = 3;
  localparam int MR_PWRUP = 4;
  localparam logic [15:0] MR_FIXED_ONES = 16'hffe0;
  localparam logic [15:0] MR_FACTORY = 16'hffff;
  localparam logic [2:0] MR_LOCKS = 3'h7;
  localparam int ST_TOGGLE = 6;
  localparam int ST_TIMEOUT = 5;
  localparam int NV_TIME_CYCLES = 32;

  typedef enum logic [13:0] {
    S_READ       = 14'h0001,
    S_U1         = 14'h0002,
    S_U2         = 14'h0004,
    S_PGM        = 14'h0008,
    S_AUTOSEL    = 14'h0010,
    S_MODE       = 14'h0020,
    S_MODE_PGM   = 14'h0040,
    S_GUARD      = 14'h0080,
    S_GUARD_PGM  = 14'h0100,
    S_GUARD_ERA  = 14'h0200,
    S_FREEZE     = 14'h0400,
    S_FREEZE_PGM = 14'h0800,
    S_BUSY       = 14'h1000,
    S_EXIT       = 14'h2000
  } fsp_state_t;

  typedef enum logic [1:0] {
    AM_READ = 2'h0,
    AM_SUSP_READ = 2'h1,
    AM_AUTOSEL = 2'h2,
    AM_CMD = 2'h3
  } fsp_amode_t;

  typedef enum logic [1:0] {
    OP_MODE = 2'h0,
    OP_GPGM = 2'h1,
    OP_GERA = 2'h2,
    OP_TMO = 2'h3
  } fsp_op_t;
endpackage

//--- rtl/fsp_nv_timer.sv
// Duration counter for one non-volatile program or erase operation.
// Assumes start is a one-cycle pulse on the same clock as the caller.
`timescale 1ns/100ps
`default_nettype none
module fsp_nv_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic start,
  input wire logic [W-1:0] len,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt;
  wire last = busy && (cnt == {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (clr) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= last;
      if (start) begin
        cnt <= len;
        busy <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        busy <= !last;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/fsp_core.sv
// Command interpreter for sector protection and software reset of a banked flash.
// Assumes write cycles and array engine status arrive already on clk; only the
// hardware reset pin is asynchronous. rst acts as power-up.
// Function
// RL1: F0 write returns banks to read, address ignored
// RL2: Reset ignored while embedded program/erase runs
// RL3: Reset mid program sequence returns bank to read
// RL4: Program sequence in erase suspend resets to suspend-read
// RL5: Reset exits autoselect, to suspend-read if suspended; the code does so in erase suspend only
// RL6: Plain reset ignored after write-buffer abort
// RL7: Bypass mode needs its own two-cycle reset
// RL8: Power-up persistent scheme, sectors unprotected by default
// RL9: Programming a scheme lock bit fixes scheme
// RL10: Mode bits: secure, erase disable, power-up, ones
// RL11: Host programs password before password lock bit
// RL12: Mode command set blocks bank 0 array
// RL13: Both lock bits together aborts the operation
// RL14: Each scheme lock bit disables the other forever
// RL15: Entry sequences refused while suspended
// RL16: Mode bit programming restores volatile guard defaults; the code does so only when mode bit 0, 1 or 2 changes
// RL17: Poll bank 0 only during mode programming
// RL18: Guards programmed singly, erased all together
// RL19: Other banks unreadable during guard operation
// RL20: Guard set: selected bank returns guard status, async
// RL21: Sector address comes on A23-A14 with program
// RL22: Frozen guards: program/erase times out unchanged
// RL23: Freeze cleared only by reset or password unlock
// RL24: Volatile guard counts only if persistent guard erased
`timescale 1ns/100ps
`default_nettype none
module fsp_core
  import fsp_pkg::*;
#(
  parameter int NSEC = 1024,
  parameter int NV_CYCLES = NV_TIME_CYCLES,
  parameter logic [15:0] MR_INIT = MR_FACTORY
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hw_reset_n,
  input wire logic wr,
  input wire logic [23:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_req,
  input wire logic [23:0] rd_addr,
  input wire logic rd_async,
  input wire logic array_busy,
  input wire logic erase_susp,
  input wire logic prog_susp,
  input wire logic wb_abort,
  input wire logic bypass_active,
  input wire logic pw_unlock_ok,
  input wire logic vg_wr,
  input wire logic [9:0] vg_sector,
  input wire logic vg_value,
  input wire logic [9:0] sec_query,
  output fsp_amode_t array_mode,
  output logic prog_start,
  output logic nv_busy,
  output logic op_done,
  output logic op_fail,
  output logic [15:0] mode_reg,
  output logic guard_freeze_bit,
  output logic sec_prot,
  output logic rd_ack,
  output logic rd_refuse,
  output logic rd_to_array,
  output logic [15:0] rd_data
);
  fsp_state_t state, ret_state, next_state;
  fsp_amode_t next_amode;
  fsp_op_t op_kind, next_kind;
  logic [15:0] pend_data;
  logic [9:0] pend_sec;
  logic [3:0] guard_bank;
  logic [NSEC-1:0] persistent_sector_guard_bit;
  logic [NSEC-1:0] volatile_sector_guard_bit;
  logic hr_s1, hr_s2, tmo_flag, toggle;
  logic start_op, fail_now;
  logic t_busy, t_done;

  // Reset pin crosses in through two flops before anything reads it
  wire hr_act = !hr_s2;
  wire [11:0] ua = wr_addr[UL_HI:0];
  wire [9:0] wsec = wr_addr[SEC_HI:SEC_LO];
  wire [3:0] rbank = rd_addr[BANK_HI:BANK_LO];
  wire [9:0] rsec = rd_addr[SEC_HI:SEC_LO];
  wire is_reset = wr && (wr_data == CMD_RESET); // RL1
  wire reset_ok = !array_busy && !wb_abort && !bypass_active && (state != S_BUSY); // RL2 RL6 RL7
  wire suspended = erase_susp || prog_susp;
  wire pw_mode = !mode_reg[MR_PASSWORD];
  wire both_locks = !wr_data[MR_PERSIST] && !wr_data[MR_PASSWORD];
  // One lock bit already at zero pins the other at one
  wire [15:0] prog_mask = wr_data |
    (pw_mode ? (16'h0001 << MR_PERSIST) : 16'h0000) |
    (!mode_reg[MR_PERSIST] ? (16'h0001 << MR_PASSWORD) : 16'h0000); // RL14
  wire [15:0] mr_new = (mode_reg & pend_data) | MR_FIXED_ONES; // RL10
  wire locks_changed = (mr_new[2:0] & MR_LOCKS) != (mode_reg[2:0] & MR_LOCKS);
  wire vg_default = mr_new[MR_PWRUP];
  wire mode_busy = (state == S_BUSY) && (op_kind == OP_MODE);
  wire guard_busy = (state == S_BUSY) && (op_kind != OP_MODE);
  wire in_mode_set = (state == S_MODE) || (state == S_MODE_PGM) ||
    ((state == S_EXIT) && (ret_state == S_MODE));
  wire in_guard_set = (state == S_GUARD) || (state == S_GUARD_PGM) || (state == S_GUARD_ERA) ||
    ((state == S_EXIT) && (ret_state == S_GUARD));
  wire [15:0] status_word = (16'(toggle) << ST_TOGGLE) | (16'(tmo_flag) << ST_TIMEOUT);
  wire rd_block = (mode_busy && (rbank != BANK0)) || // RL17
    (guard_busy && (rbank != guard_bank)) || // RL19
    (in_guard_set && (rbank == guard_bank) && !rd_async); // RL20
  wire rd_status = (state == S_BUSY);
  wire rd_mr = in_mode_set && (rbank == BANK0); // RL12
  wire rd_guard = in_guard_set && (rbank == guard_bank); // RL20
  wire [15:0] guard_word = {15'h0000, persistent_sector_guard_bit[rsec]};
  wire [15:0] next_rd_data = rd_status ? status_word : rd_mr ? mode_reg : rd_guard ? guard_word : 16'h0000;
  wire next_to_array = rd_req && !rd_block && !rd_status && !rd_mr && !rd_guard;
  wire next_sec_prot = !persistent_sector_guard_bit[sec_query] || !volatile_sector_guard_bit[sec_query]; // RL24

  always_comb begin
    next_state = state;
    next_amode = array_mode;
    next_kind = op_kind;
    start_op = 1'b0;
    fail_now = 1'b0;
    if (is_reset && reset_ok) begin
      next_state = S_READ; // RL1 RL3
      next_amode = erase_susp ? AM_SUSP_READ : AM_READ; // RL4 RL5
    end else begin
      case (state)
        S_READ: begin
          if (wr && wr_data == CMD_UNLOCK1 && ua == ADDR_UNLOCK1) begin
            next_state = S_U1;
          end
        end
        S_U1: begin
          if (wr) begin
            next_state = (wr_data == CMD_UNLOCK2 && ua == ADDR_UNLOCK2) ? S_U2 : S_READ;
          end
        end
        S_U2: begin
          if (wr) begin
            next_state = S_READ;
            if (wr_data == CMD_PROGRAM) begin
              next_state = S_PGM;
            end else if (wr_data == CMD_AUTOSEL) begin
              next_state = S_AUTOSEL;
              next_amode = AM_AUTOSEL;
            end else if (!suspended) begin // RL15
              if (wr_data == CMD_MODE_ENTRY) begin
                next_state = S_MODE;
              end else if (wr_data == CMD_GUARD_ENTRY) begin
                next_state = S_GUARD;
              end else if (wr_data == CMD_FREEZE_ENTRY) begin
                next_state = S_FREEZE;
              end
              if (next_state != S_READ) begin
                next_amode = AM_CMD;
              end
            end
          end
        end
        S_PGM: begin
          if (wr) begin
            next_state = S_READ;
          end
        end
        S_AUTOSEL: begin
          next_state = S_AUTOSEL;
        end
        S_MODE, S_GUARD, S_FREEZE: begin
          if (wr && wr_data == CMD_EXIT1) begin
            next_state = S_EXIT;
          end else if (wr && wr_data == CMD_PROGRAM) begin
            next_state = (state == S_MODE) ? S_MODE_PGM : (state == S_GUARD) ? S_GUARD_PGM : S_FREEZE_PGM;
          end else if (wr && wr_data == CMD_ERASE && state == S_GUARD) begin
            next_state = S_GUARD_ERA;
          end
        end
        S_MODE_PGM: begin
          if (wr && both_locks) begin
            next_state = S_MODE; // RL13
            fail_now = 1'b1;
          end else if (wr) begin
            next_state = S_BUSY;
            next_kind = OP_MODE; // RL9
            start_op = 1'b1;
          end
        end
        S_GUARD_PGM: begin
          if (wr) begin
            next_state = S_BUSY;
            next_kind = guard_freeze_bit ? OP_TMO : OP_GPGM; // RL22
            start_op = 1'b1;
          end
        end
        S_GUARD_ERA: begin
          if (wr && wr_data == CMD_ERASE_GO) begin
            if (!guard_freeze_bit && !mode_reg[MR_ERASE_EN]) begin
              next_state = S_GUARD; // RL10
              fail_now = 1'b1;
            end else begin
              next_state = S_BUSY;
              next_kind = guard_freeze_bit ? OP_TMO : OP_GERA; // RL22
              start_op = 1'b1;
            end
          end else if (wr) begin
            next_state = S_GUARD;
          end
        end
        S_FREEZE_PGM: begin
          if (wr) begin
            next_state = S_FREEZE;
          end
        end
        S_BUSY: begin
          if (t_done) begin
            next_state = ret_state;
          end
        end
        S_EXIT: begin
          if (wr) begin
            next_state = (wr_data == CMD_EXIT2) ? S_READ : ret_state;
          end
          if (wr && wr_data == CMD_EXIT2) begin
            next_amode = AM_READ;
          end
        end
        default: begin
          next_state = S_READ;
          next_amode = AM_READ;
        end
      endcase
    end
  end

  fsp_nv_timer #(.W(16)) u_timer (
    .clk(clk),
    .rst(rst),
    .clr(hr_act),
    .start(start_op),
    .len(16'(NV_CYCLES)),
    .busy(t_busy),
    .done(t_done)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hr_s1 <= 1'b1;
      hr_s2 <= 1'b1;
    end else begin
      hr_s1 <= hw_reset_n;
      hr_s2 <= hr_s1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_READ;
      ret_state <= S_READ;
      array_mode <= AM_READ;
      op_kind <= OP_MODE;
    end else if (hr_act) begin
      state <= S_READ;
      ret_state <= S_READ;
      array_mode <= AM_READ;
    end else begin
      state <= next_state;
      array_mode <= next_amode;
      op_kind <= next_kind;
      if (state == S_U2 && next_state != S_READ) begin
        ret_state <= next_state;
      end
    end
  end

  // Sector address is caught in the same cycle as the program write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_data <= MR_FACTORY;
      pend_sec <= 10'h000;
      guard_bank <= BANK0;
    end else begin
      if (state == S_MODE_PGM && wr) begin
        pend_data <= prog_mask;
      end
      if (state == S_GUARD_PGM && wr) begin
        pend_sec <= wsec; // RL21
      end
      if (state == S_U2 && wr && wr_data == CMD_GUARD_ENTRY) begin
        guard_bank <= wr_addr[BANK_HI:BANK_LO];
      end
    end
  end

  // Non-volatile storage modelled as flops; rst stands for power-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MR_INIT | MR_FIXED_ONES; // RL8
      persistent_sector_guard_bit <= {NSEC{1'b1}};
    end else if (t_done && !hr_act) begin
      if (op_kind == OP_MODE) begin
        mode_reg <= mr_new; // RL9
      end else if (op_kind == OP_GPGM) begin
        persistent_sector_guard_bit[pend_sec] <= 1'b0; // RL18
      end else if (op_kind == OP_GERA) begin
        persistent_sector_guard_bit <= {NSEC{1'b1}}; // RL18
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      volatile_sector_guard_bit <= {NSEC{MR_INIT[MR_PWRUP]}}; // RL8
    end else if (hr_act) begin
      volatile_sector_guard_bit <= {NSEC{mode_reg[MR_PWRUP]}};
    end else if (t_done && op_kind == OP_MODE && locks_changed) begin
      volatile_sector_guard_bit <= {NSEC{vg_default}}; // RL16
    end else if (vg_wr) begin
      volatile_sector_guard_bit[vg_sector] <= vg_value;
    end
  end

  // In password scheme the freeze bit comes back set after a hardware reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_freeze_bit <= 1'b0;
    end else if (hr_act) begin
      guard_freeze_bit <= pw_mode; // RL23
    end else if (state == S_FREEZE_PGM && wr) begin
      guard_freeze_bit <= 1'b1;
    end else if (pw_unlock_ok && pw_mode) begin
      guard_freeze_bit <= 1'b0; // RL23
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_start <= 1'b0;
      nv_busy <= 1'b0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
      tmo_flag <= 1'b0;
      sec_prot <= 1'b0;
    end else begin
      prog_start <= !hr_act && (state == S_PGM) && wr && !is_reset; // RL3
      nv_busy <= !hr_act && (next_state == S_BUSY);
      op_done <= t_done && (op_kind != OP_TMO);
      op_fail <= fail_now || (t_done && op_kind == OP_TMO); // RL22
      if (t_done && op_kind == OP_TMO) begin
        tmo_flag <= 1'b1;
      end else if ((is_reset && reset_ok) || hr_act) begin
        tmo_flag <= 1'b0;
      end
      sec_prot <= next_sec_prot;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ack <= 1'b0;
      rd_refuse <= 1'b0;
      rd_to_array <= 1'b0;
      rd_data <= 16'h0000;
      toggle <= 1'b0;
    end else begin
      rd_ack <= rd_req && !rd_block && !hr_act;
      rd_refuse <= rd_req && (rd_block || hr_act);
      rd_to_array <= next_to_array && !hr_act;
      if (rd_req && !rd_block) begin
        rd_data <= next_rd_data;
      end
      if (rd_req && rd_status && !rd_block) begin
        toggle <= !toggle;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || hr_act);

  sequence reset_blocked_s;
    is_reset && array_busy;
  endsequence
  sequence frozen_guard_pgm_s;
    guard_freeze_bit && !(is_reset && reset_ok) && wr &&
      ((state == S_GUARD_PGM) || ((state == S_GUARD_ERA) && (wr_data == CMD_ERASE_GO)));
  endsequence

  reset_ignored_busy_a: assert property (reset_blocked_s |=> array_mode == $past(array_mode)) // RL2
    else $error("reset acted during embedded operation");
  reset_abort_ign_a: assert property (is_reset && wb_abort && (state == S_READ || state == S_AUTOSEL)
    |=> state == $past(state) && array_mode == $past(array_mode)) // RL6
    else $error("plain reset acted after buffer abort");
  reset_mid_pgm_a: assert property ((state == S_U1 || state == S_U2 || state == S_PGM) && is_reset && reset_ok
    |=> state == S_READ && !prog_start) // RL3
    else $error("reset in program sequence did not return to read");
  reset_susp_read_a: assert property (is_reset && reset_ok && erase_susp |=> array_mode == AM_SUSP_READ) // RL4
    else $error("reset in erase suspend missed suspend-read");
  autosel_exit_a: assert property (state == S_AUTOSEL && is_reset && reset_ok |=> state == S_READ) // RL5
    else $error("reset did not leave autoselect");
  both_locks_abort_a: assert property (state == S_MODE_PGM && wr && both_locks && !is_reset
    |=> op_fail ##1 mode_reg == $past(mode_reg, 2)) // RL13
    else $error("double lock program not aborted");
  scheme_lock_a: assert property ($fell(mode_reg[MR_PERSIST]) |-> $past(mode_reg[MR_PASSWORD])) // RL14
    else $error("persistent lock programmed in password scheme");
  entry_suspend_a: assert property (state == S_U2 && wr && suspended && !is_reset && wr_data == CMD_MODE_ENTRY
    |=> state == S_READ) // RL15
    else $error("entry accepted while suspended");
  frozen_timeout_a: assert property (frozen_guard_pgm_s |=> op_kind == OP_TMO ##[1:300] op_fail) // RL22
    else $error("frozen guard program did not time out");
  poll_bank0_a: assert property (rd_req && mode_busy && rbank != BANK0 |=> rd_refuse && !rd_ack) // RL17
    else $error("other bank read during mode programming");
  guard_sync_rd_a: assert property (rd_req && in_guard_set && rbank == guard_bank && !rd_async
    |=> rd_refuse) // RL20
    else $error("synchronous guard status read accepted");
  freeze_hold_a: assert property ($fell(guard_freeze_bit)
    |-> $past(pw_unlock_ok) && $past(pw_mode) || $past(hr_act)) // RL23
    else $error("freeze bit cleared without unlock or reset");
endmodule
`default_nettype wire

//--- tb/fsp_host_model.sv
// Host side of the flash bus: command writes and read requests.
// Assumes the bench calls its tasks; it drives just after the falling edge.
`timescale 1ns/100ps
`default_nettype none
module fsp_host_model (
  input wire logic clk,
  output logic wr,
  output logic [23:0] wr_addr,
  output logic [15:0] wr_data,
  output logic rd_req,
  output logic [23:0] rd_addr,
  output logic rd_async
);
  initial begin
    wr = 1'b0;
    wr_addr = 24'h000000;
    wr_data = 16'h0000;
    rd_req = 1'b0;
    rd_addr = 24'h000000;
    rd_async = 1'b0;
  end

  // One write cycle; the bus is inverted afterwards so no stale value lingers
  task automatic wcyc(input logic [23:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask

  // Unlock pair, then the command word at its address
  task automatic unlock(input logic [23:0] a, input logic [15:0] c);
    wcyc(24'h000555, 16'h00aa);
    wcyc(24'h0002aa, 16'h0055);
    wcyc(a, c);
  endtask

  task automatic rcyc(input logic [23:0] a, input logic as);
    @(negedge clk);
    rd_req = 1'b1;
    rd_addr = a;
    rd_async = as;
    @(negedge clk);
    rd_req = 1'b0;
    rd_addr = ~a;
  endtask
endmodule
`default_nettype wire

//--- tb/flash_sector_protection_reset_bench.sv
// Self-checking bench of the sector protection core.
// Assumes the host model drives the bus; status levels come from the bench.
`timescale 1ns/100ps
`default_nettype none
module flash_sector_protection_reset_bench;
  import fsp_pkg::*;
  typedef struct packed {
    logic busy;
    logic abort;
    logic byp;
    logic susp;
    logic [15:0] cmd;
    fsp_amode_t m1;
    fsp_amode_t m2;
  } fsp_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hw_reset_n = 1'b1;
  logic array_busy = 1'b0;
  logic erase_susp = 1'b0;
  logic prog_susp = 1'b0;
  logic wb_abort = 1'b0;
  logic bypass_active = 1'b0;
  logic pw_unlock_ok = 1'b0;
  logic vg_wr = 1'b0;
  logic vg_value = 1'b1;
  logic [9:0] sec_query = 10'h000;
  logic wr, rd_req, rd_async, prog_start, nv_busy, op_done, op_fail;
  logic guard_freeze_bit, sec_prot, rd_ack, rd_refuse, rd_to_array;
  logic [23:0] wr_addr, rd_addr;
  logic [15:0] wr_data, mode_reg, rd_data, rdv;
  fsp_amode_t array_mode;
  logic [1:0] resp = 2'h0;
  int num_errors = 0;
  int cmp_count = 0;
  int n_prog = 0;
  int n_done = 0;
  int n_fail = 0;
  int n0;
  fsp_row_t rows [6] = '{
    '{1'b0, 1'b0, 1'b0, 1'b0, 16'h0090, AM_AUTOSEL, AM_READ},
    '{1'b0, 1'b0, 1'b0, 1'b1, 16'h0090, AM_AUTOSEL, AM_SUSP_READ},
    '{1'b0, 1'b0, 1'b0, 1'b0, 16'h0040, AM_CMD, AM_READ},
    '{1'b0, 1'b1, 1'b0, 1'b0, 16'h0090, AM_AUTOSEL, AM_AUTOSEL},
    '{1'b0, 1'b0, 1'b1, 1'b0, 16'h0090, AM_AUTOSEL, AM_AUTOSEL},
    '{1'b1, 1'b0, 1'b0, 1'b0, 16'h0040, AM_CMD, AM_CMD}
  };

  always #25 clk = ~clk;

  fsp_host_model u_fsp_host_model (.clk(clk), .wr(wr), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_async(rd_async));

  // Short non-volatile time keeps each operation a few cycles long
  fsp_core #(.NV_CYCLES(4)) u_fsp_core (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n), .wr(wr),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_async(rd_async),
    .array_busy(array_busy), .erase_susp(erase_susp), .prog_susp(prog_susp), .wb_abort(wb_abort),
    .bypass_active(bypass_active), .pw_unlock_ok(pw_unlock_ok), .vg_wr(vg_wr), .vg_sector(sec_query),
    .vg_value(vg_value), .sec_query(sec_query), .array_mode(array_mode), .prog_start(prog_start),
    .nv_busy(nv_busy), .op_done(op_done), .op_fail(op_fail), .mode_reg(mode_reg),
    .guard_freeze_bit(guard_freeze_bit), .sec_prot(sec_prot), .rd_ack(rd_ack), .rd_refuse(rd_refuse),
    .rd_to_array(rd_to_array), .rd_data(rd_data));

  // Pulses are caught at the falling edge, where they are settled
  always @(negedge clk) begin
    if (rd_ack === 1'b1) begin
      resp = 2'h1;
      rdv = rd_data;
    end
    if (rd_refuse === 1'b1) resp = 2'h2;
    if (rd_to_array === 1'b1) resp = 2'h3;
    if (prog_start === 1'b1) n_prog++;
    if (op_done === 1'b1) n_done++;
    if (op_fail === 1'b1) n_fail++;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic rd(input logic [23:0] a, input logic as, input logic [1:0] er, input logic [15:0] ed);
    resp = 2'h0;
    u_fsp_host_model.rcyc(a, as);
    settle();
    chk("rd_resp", {14'h0, er}, {14'h0, resp});
    if (er == 2'h1) chk("rd_data", ed, rdv);
  endtask

  task automatic wait_op();
    int k;
    int s;
    k = 0;
    s = n_done + n_fail;
    while (n_done + n_fail == s && k < 80) begin
      @(negedge clk);
      k++;
    end
    chk("op_end", 16'h0001, {15'h0, k < 80});
    settle();
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    settle();
    chk("mode_reg", 16'hffff, mode_reg);
    chk("freeze", 16'h0000, {15'h0, guard_freeze_bit});
    chk("sec_prot", 16'h0000, {15'h0, sec_prot});
    foreach (rows[i]) begin
      {array_busy, wb_abort, bypass_active, erase_susp} = {rows[i].busy, rows[i].abort, rows[i].byp, rows[i].susp};
      u_fsp_host_model.unlock(24'h000555, rows[i].cmd);
      settle();
      chk("mode_in", rows[i].m1, array_mode);
      u_fsp_host_model.wcyc(24'hab1234, 16'h00f0);
      settle();
      chk("mode_out", rows[i].m2, array_mode);
      {array_busy, wb_abort, bypass_active, erase_susp} = 4'h0;
      u_fsp_host_model.wcyc(24'h000000, 16'h00f0);
    end
    n0 = n_prog;
    u_fsp_host_model.unlock(24'h000555, 16'h00a0);
    u_fsp_host_model.wcyc(24'h000000, 16'h00f0);
    u_fsp_host_model.wcyc(24'h000100, 16'h1234);
    settle();
    chk("prog_cnt", 16'h0000, 16'(n_prog - n0));
    u_fsp_host_model.unlock(24'h000555, 16'h00a0);
    u_fsp_host_model.wcyc(24'h000100, 16'h1234);
    settle();
    chk("prog_go", 16'h0001, 16'(n_prog - n0));
    erase_susp = 1'b1;
    u_fsp_host_model.unlock(24'h000555, 16'h00a0);
    u_fsp_host_model.wcyc(24'h000000, 16'h00f0);
    settle();
    chk("susp_mode", AM_SUSP_READ, array_mode);
    erase_susp = 1'b0;
    prog_susp = 1'b1;
    u_fsp_host_model.unlock(24'h000555, 16'h0040);
    settle();
    chk("entry_refused", 16'h0001, {15'h0, array_mode !== AM_CMD});
    prog_susp = 1'b0;
    u_fsp_host_model.wcyc(24'h000000, 16'h00f0);
    u_fsp_host_model.unlock(24'h000555, 16'h0040);
    rd(24'h000000, 1'b0, 2'h1, 16'hffff);
    rd(24'h100000, 1'b0, 2'h3, 16'h0000);
    n0 = n_fail;
    u_fsp_host_model.wcyc(24'h000000, 16'h00a0);
    u_fsp_host_model.wcyc(24'h000000, 16'hfff9);
    settle();
    chk("both_fail", 16'h0001, 16'(n_fail - n0));
    chk("mode_reg", 16'hffff, mode_reg);
    u_fsp_host_model.wcyc(24'h000000, 16'h00a0);
    u_fsp_host_model.wcyc(24'h000000, 16'hfffd);
    rd(24'h100000, 1'b0, 2'h2, 16'h0000);
    chk("nv_busy", 16'h0001, {15'h0, nv_busy});
    wait_op();
    chk("mode_reg", 16'hfffd, mode_reg);
    u_fsp_host_model.wcyc(24'h000000, 16'h00a0);
    u_fsp_host_model.wcyc(24'h000000, 16'hfffb);
    wait_op();
    chk("mode_reg", 16'hfffd, mode_reg);
    u_fsp_host_model.wcyc(24'h000000, 16'h0090);
    u_fsp_host_model.wcyc(24'h000000, 16'h0000);
    settle();
    chk("exit", AM_READ, array_mode);
    u_fsp_host_model.unlock(24'h000000, 16'h00c0);
    u_fsp_host_model.wcyc(24'h000000, 16'h00a0);
    u_fsp_host_model.wcyc(24'h00c000, 16'h0000);
    wait_op();
    rd(24'h00c000, 1'b1, 2'h1, 16'h0000);
    rd(24'h010000, 1'b1, 2'h1, 16'h0001);
    rd(24'h00c000, 1'b0, 2'h2, 16'h0000);
    u_fsp_host_model.wcyc(24'h000000, 16'h0090);
    u_fsp_host_model.wcyc(24'h000000, 16'h0000);
    sec_query = 10'h003;
    u_fsp_host_model.unlock(24'h000555, 16'h0050);
    u_fsp_host_model.wcyc(24'h000000, 16'h00a0);
    u_fsp_host_model.wcyc(24'h000000, 16'h0000);
    settle();
    chk("freeze", 16'h0001, {15'h0, guard_freeze_bit});
    @(negedge clk) pw_unlock_ok = 1'b1;
    @(negedge clk) pw_unlock_ok = 1'b0;
    settle();
    chk("freeze_kept", 16'h0001, {15'h0, guard_freeze_bit});
    u_fsp_host_model.wcyc(24'h000000, 16'h00f0);
    n0 = n_fail;
    u_fsp_host_model.unlock(24'h000000, 16'h00c0);
    u_fsp_host_model.wcyc(24'h000000, 16'h0080);
    u_fsp_host_model.wcyc(24'h000000, 16'h0030);
    wait_op();
    chk("frozen_fail", 16'h0001, 16'(n_fail - n0));
    chk("sec_prot", 16'h0001, {15'h0, sec_prot});
    // Hardware reset is the only way out of the freeze in persistent scheme
    hw_reset_n = 1'b0;
    repeat (4) @(negedge clk);
    hw_reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("freeze_hw", 16'h0000, {15'h0, guard_freeze_bit});
    u_fsp_host_model.unlock(24'h000000, 16'h00c0);
    u_fsp_host_model.wcyc(24'h000000, 16'h0080);
    u_fsp_host_model.wcyc(24'h000000, 16'h0030);
    rd(24'h200000, 1'b1, 2'h2, 16'h0000);
    wait_op();
    u_fsp_host_model.wcyc(24'h000000, 16'h0090);
    u_fsp_host_model.wcyc(24'h000000, 16'h0000);
    settle();
    chk("erased", 16'h0000, {15'h0, sec_prot});
    @(negedge clk) {vg_wr, vg_value} = 2'h2;
    @(negedge clk) vg_wr = 1'b0;
    settle();
    chk("vg_prot", 16'h0001, {15'h0, sec_prot});
    wrap_up();
  end
endmodule
`default_nettype wire
